/* File: hdl/slm_lane_pack.sv */
/*
  Packs up to five samples of one lane into a 64-bit frame word,
  first octet in the top bits. Purely combinational; the caller
  registers the result.
*/
module slm_lane_pack
  import slm_pkg::*;
(
  input slm_fmt_e fmt,
  input wire logic [SET_N-1:0][SMP_W-1:0] set,
  output logic [LANE_W-1:0] word
);

  always_comb begin
    word = LANE_RST;
    case (fmt)
      FMT_N12: begin
        for (int i = 0; i < N12_CNT; i++) begin
          word[LANE_W-1-FIELD12_W*i -: FIELD12_W] = pad12(set[i]);
        end
        word[TAIL_W-1:0] = '0;
      end
      FMT_O8: begin
        // octet mode takes the upper eight bits of the lane's single sample, set[0]
        word[LANE_W-1 -: OCTET_W] = set[0][SMP_W-1 -: OCTET_W];
      end
      FMT_N10: begin
        for (int i = 0; i < N10_CNT; i++) begin
          word[LANE_W-1-FIELD10_W*i -: FIELD10_W] = pad10(set[i]);
        end
      end
      FMT_P12: begin
        for (int i = 0; i < P12_CNT; i++) begin
          word[LANE_W-1-FIELD12_W*i -: FIELD12_W] = pad12(set[i]);
        end
      end
      default: word = LANE_RST;
    endcase
  end

endmodule

/* File: hdl/slm_mapper.sv */
/*
  Lane sample mapper: takes one frame of channel samples per accepted
  handshake and places them on eight lane words for the link encoder.
  Assumes the mode and variant inputs come from same-clock logic and
  are held steady while frames flow.
*/
module slm_mapper
  import slm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] transport_mode_select,
  input slm_variant_e variant,
  input slm_frame_s in_frame,
  input wire logic in_valid,
  output logic in_ready,
  output slm_lanes_s out_lanes,
  output logic out_valid,
  input wire logic out_ready,
  output logic mode_err
);

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  function automatic slm_fmt_e decode_fmt(input logic [3:0] code,
                                          input slm_variant_e v);
    decode_fmt = FMT_NONE;
    // the wide modes exist only for single and dual parts
    if (code == MODE_N12_8B) begin
      if (v != VAR_QUAD) decode_fmt = FMT_N12;
    end else if (code == MODE_O8_66) begin
      if (v != VAR_QUAD) decode_fmt = FMT_O8;
    end else if (code == MODE_N10_8B) begin
      if (v != VAR_QUAD) decode_fmt = FMT_N10;
    end else if (code == MODE_P12_66) begin
      decode_fmt = FMT_P12;
    end
  endfunction

  function automatic logic [NUM_LANES-1:0] lane_mask(input slm_fmt_e f,
                                                     input slm_variant_e v);
    lane_mask = EN_RST;
    case (f)
      FMT_N12, FMT_O8, FMT_N10: begin
        lane_mask = (v == VAR_DUAL) ? EN_ALL : EN_LOW4;
      end
      FMT_P12: begin
        if (v == VAR_QUAD) begin
          lane_mask = EN_ALL;
        end else if (v == VAR_DUAL) begin
          lane_mask = EN_LOW4;
        end else begin
          lane_mask = EN_LOW2;
        end
      end
      default: lane_mask = EN_RST;
    endcase
  endfunction

  function automatic logic [3:0] octet_count(input slm_fmt_e f);
    octet_count = OCT_NONE;
    case (f)
      FMT_N12: octet_count = OCT_N12;
      FMT_O8: octet_count = OCT_O8;
      FMT_N10: octet_count = OCT_N10;
      FMT_P12: octet_count = OCT_P12;
      default: octet_count = OCT_NONE;
    endcase
  endfunction

  slm_fmt_e fmt;
  logic [NUM_LANES-1:0] en_mask;

  always_comb begin
    fmt = decode_fmt(transport_mode_select, variant);
    en_mask = lane_mask(fmt, variant);
  end

  // ----------------------------------------------------------------
  // sample selection per lane
  // ----------------------------------------------------------------
  logic [NUM_LANES-1:0][SET_N-1:0][SMP_W-1:0] lane_set;
  logic [NUM_LANES-1:0][LANE_W-1:0] lane_word;

  for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
    localparam int WCH = l / LANES_PER_CH_WIDE;
    localparam int WOFS = l % LANES_PER_CH_WIDE;
    localparam int PCH = l / LANES_PER_CH_PAIR;
    localparam int POFS = l % LANES_PER_CH_PAIR;

    always_comb begin
      lane_set[l] = '0;
      // disabled lanes stay at zero so unused serializers see no data
      if (en_mask[l]) begin
        case (fmt)
          FMT_N12: begin
            for (int i = 0; i < N12_CNT; i++) begin
              lane_set[l][i] =
                in_frame.smp[WCH][WOFS+LANES_PER_CH_WIDE*i];
            end
          end
          FMT_O8: begin
            lane_set[l][0] = in_frame.smp[WCH][WOFS];
          end
          FMT_N10: begin
            for (int i = 0; i < N10_CNT; i++) begin
              lane_set[l][i] =
                in_frame.smp[WCH][WOFS+LANES_PER_CH_WIDE*i];
            end
          end
          FMT_P12: begin
            for (int i = 0; i < P12_CNT; i++) begin
              lane_set[l][i] =
                in_frame.smp[PCH][POFS+LANES_PER_CH_PAIR*i];
            end
          end
          default: lane_set[l] = '0;
        endcase
      end
    end

    slm_lane_pack u_pack (
      .fmt(fmt),
      .set(lane_set[l]),
      .word(lane_word[l])
    );
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  slm_lanes_s lanes_q, lanes_d;
  logic valid_q, valid_d;
  logic err_q, err_d;
  logic take;

  // a frame is taken whenever the output slot is free or draining
  assign in_ready = !valid_q || out_ready;
  assign take = in_valid && in_ready;

  always_comb begin
    lanes_d = lanes_q;
    valid_d = valid_q;
    err_d = err_q;
    if (take) begin
      lanes_d.word = lane_word;
      lanes_d.lane_en = en_mask;
      lanes_d.octets = octet_count(fmt);
      valid_d = 1'b1;
      // unsupported selection still passes an all-zero frame
      err_d = (fmt == FMT_NONE);
    end else if (out_ready) begin
      valid_d = 1'b0;
      // the flag belongs to the frame, so it leaves with it
      err_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lanes_q.word <= '0;
      lanes_q.lane_en <= EN_RST;
      lanes_q.octets <= OCT_NONE;
      valid_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      lanes_q <= lanes_d;
      valid_q <= valid_d;
      err_q <= err_d;
    end
  end

  assign out_lanes = lanes_q;
  assign out_valid = valid_q;
  assign mode_err = err_q;

endmodule

/* File: hdl/slm_pkg.sv */
/*
  Constants, types and helpers shared by the lane sample mapper.
  Assumes a single frame clock; one whole frame moves per cycle.
*/
// Overview of operation
// - twelve-bit mode: lane k takes samples k..k+16
// - octet mode: lanes 0-3 first, 4-7 second
// - ten-bit mode: lane k takes samples k..k+12
// - paired lanes: even 0,2, odd 1,3
package slm_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_LANES = 8;
  localparam int NUM_CH = 4;
  localparam int SMP_PER_CH = 20;
  localparam int SMP_W = 9;
  localparam int LANE_W = 64;
  localparam int SET_N = 5;
  localparam int LANES_PER_CH_WIDE = 4;
  localparam int LANES_PER_CH_PAIR = 2;
  localparam int FIELD12_W = 12;
  localparam int FIELD10_W = 10;
  localparam int OCTET_W = 8;
  localparam int TAIL_W = 4;
  localparam int N12_CNT = 5;
  localparam int N10_CNT = 4;
  localparam int P12_CNT = 2;

  // ----------------------------------------------------------------
  // transport mode codes and octets per frame
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_N12_8B = 4'hb;
  localparam logic [3:0] MODE_O8_66 = 4'hc;
  localparam logic [3:0] MODE_N10_8B = 4'hd;
  localparam logic [3:0] MODE_P12_66 = 4'he;
  localparam logic [3:0] OCT_N12 = 4'h8;
  localparam logic [3:0] OCT_O8 = 4'h1;
  localparam logic [3:0] OCT_N10 = 4'h5;
  localparam logic [3:0] OCT_P12 = 4'h3;
  localparam logic [3:0] OCT_NONE = 4'h0;

  // ----------------------------------------------------------------
  // reset values and lane enable masks
  // ----------------------------------------------------------------
  localparam logic [LANE_W-1:0] LANE_RST = 64'h0;
  localparam logic [NUM_LANES-1:0] EN_RST = 8'h00;
  localparam logic [NUM_LANES-1:0] EN_LOW4 = 8'h0f;
  localparam logic [NUM_LANES-1:0] EN_ALL = 8'hff;
  localparam logic [NUM_LANES-1:0] EN_LOW2 = 8'h03;

  typedef enum logic [4:0] {
    FMT_NONE = 5'h01,
    FMT_N12 = 5'h02,
    FMT_O8 = 5'h04,
    FMT_N10 = 5'h08,
    FMT_P12 = 5'h10
  } slm_fmt_e;

  typedef enum logic [1:0] {
    VAR_SINGLE = 2'h0,
    VAR_DUAL = 2'h1,
    VAR_QUAD = 2'h2
  } slm_variant_e;

  typedef logic [SMP_W-1:0] slm_smp_t;

  typedef struct packed {
    logic [NUM_CH-1:0][SMP_PER_CH-1:0][SMP_W-1:0] smp;
  } slm_frame_s;

  typedef struct packed {
    logic [NUM_LANES-1:0][LANE_W-1:0] word;
    logic [NUM_LANES-1:0] lane_en;
    logic [3:0] octets;
  } slm_lanes_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [FIELD12_W-1:0] pad12(input slm_smp_t s);
    pad12 = {s, 3'h0};
  endfunction

  function automatic logic [FIELD10_W-1:0] pad10(input slm_smp_t s);
    pad10 = {s, 1'h0};
  endfunction

endpackage

/* File: tb/slm_mapper_chk.sv */
/* checker for the lane sample mapper.
   bound to slm_mapper; sees only its ports */
module slm_mapper_chk
  import slm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] transport_mode_select,
  input slm_variant_e variant,
  input wire logic in_valid,
  input wire logic in_ready,
  input slm_lanes_s out_lanes,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic mode_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tz;
  logic ok;
  logic [3:0] m;
  assign m = transport_mode_select;
  assign ok = out_valid && !mode_err;
  always_comb begin
    tz = 1'b1;
    for (int l = 0; l < NUM_LANES; l++) tz &= out_lanes.word[l][3:0] == 4'h0;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_ready_stall: assert property (in_ready == (!out_valid || out_ready))
    else $error("ready wrong");
  a_hold_stall: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_lanes) && $stable(mode_err))
    else $error("frame not held");
  a_take_answer: assert property (in_valid && in_ready |=> out_valid)
    else $error("no frame after take");
  a_drop_idle: assert property (out_valid && out_ready && !in_valid |=>
    !out_valid) else $error("valid stuck");
  a_twelve_tail: assert property (ok && m == MODE_N12_8B |-> tz &&
    out_lanes.octets == OCT_N12) else $error("tail not zero");
  a_twelve_lanes: assert property (ok && m == MODE_N12_8B |->
    out_lanes.lane_en == (variant == VAR_DUAL ? EN_ALL : EN_LOW4))
    else $error("lane enable wrong");
  a_octet_mode: assert property (ok && m == MODE_O8_66 |->
    out_lanes.octets == OCT_O8 && out_lanes.word[0][55:0] == 56'h0)
    else $error("octet mode wrong");
  a_ten_bit: assert property (ok && m == MODE_N10_8B |->
    out_lanes.octets == OCT_N10 && out_lanes.word[3][23:0] == 24'h0)
    else $error("ten-bit mode wrong");
  a_pair_lanes: assert property (ok && m == MODE_P12_66 |->
    out_lanes.lane_en == (variant == VAR_SINGLE ? EN_LOW2 :
    variant == VAR_DUAL ? EN_LOW4 : EN_ALL)) else $error("pair lanes");
  a_err_blank: assert property (mode_err |-> out_valid &&
    out_lanes.lane_en == 8'h00 && out_lanes.octets == OCT_NONE)
    else $error("error frame not blank");
endmodule

bind slm_mapper slm_mapper_chk slm_mapper_chk_i (.*);

/* File: tb/slm_mapper_tb_top.sv */
/* self-checking bench for the lane sample mapper.
   assumes slm_sink as far side and the bound checker */
module slm_mapper_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import slm_pkg::*;
  localparam int RW = $bits(slm_lanes_s) + 1;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] mode = 4'h0;
  slm_variant_e variant = VAR_SINGLE;
  slm_frame_s in_frame = '0;
  logic in_valid = 1'b0;
  logic in_ready, out_valid, out_ready, mode_err, tk;
  slm_lanes_s out_lanes;
  logic [RW-1:0] exq[$];
  logic [3:0] md[5] = '{MODE_N12_8B, MODE_O8_66, MODE_N10_8B,
    MODE_P12_66, 4'h7};
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  always #20 sys_clk = ~sys_clk;
  slm_mapper slm_mapper_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .transport_mode_select(mode), .variant(variant),
    .in_frame(in_frame), .in_valid(in_valid), .in_ready(in_ready),
    .out_lanes(out_lanes), .out_valid(out_valid),
    .out_ready(out_ready), .mode_err(mode_err));
  slm_sink slm_sink_i (.sys_clk(sys_clk), .out_ready(out_ready));
  // ------------------------------------------------------------
  // expected lane frame, error flag on top
  // ------------------------------------------------------------
  function automatic logic [RW-1:0] expect_of(logic [3:0] mo,
      slm_variant_e vr, slm_frame_s f);
    slm_lanes_s e;
    int n, fw, lpc, nl;
    logic [11:0] v;
    e = '0;
    n = 0;
    fw = 12;
    lpc = 4;
    case (mo)
      MODE_N12_8B: begin n = 5; e.octets = OCT_N12; end
      MODE_O8_66: begin n = 1; fw = 8; e.octets = OCT_O8; end
      MODE_N10_8B: begin n = 4; fw = 10; e.octets = OCT_N10; end
      MODE_P12_66: begin n = 2; lpc = 2; e.octets = OCT_P12; end
      default: ;
    endcase
    nl = lpc * (vr == VAR_QUAD ? 4 : int'(vr) + 1);
    if (n == 0 || nl > NUM_LANES) return {1'b1, {(RW-1){1'b0}}};
    e.lane_en = 8'((16'h1 << nl) - 16'h1);
    // pad below the sample, 8-bit mode drops the lsb
    for (int l = 0; l < nl; l++)
      for (int i = 0; i < n; i++) begin
        v = {f.smp[l / lpc][l % lpc + lpc * i], 3'h0} >> (12 - fw);
        e.word[l] |= 64'(v) << (64 - fw * (i + 1));
      end
    return {1'b0, e};
  endfunction
  task automatic check(logic [RW-1:0] seen, logic [RW-1:0] exp,
      string nm);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic send();
    for (int c = 0; c < NUM_CH; c++)
      for (int s = 0; s < SMP_PER_CH; s++) in_frame.smp[c][s] = 9'($urandom);
    in_valid = 1'b1;
    exq.push_back(expect_of(mode, variant, in_frame));
    do @(negedge sys_clk); while (!tk);
  endtask
  // ------------------------------------------------------------
  // monitor and timeout
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    tk <= in_valid && in_ready;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      end_of_test();
    end
    if (!sys_rst && out_valid === 1'b1 && out_ready === 1'b1)
      check({mode_err, out_lanes}, exq.size() ? exq.pop_front() : '1,
        "lanes");
  end
  initial begin
    void'($urandom(83136));
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    foreach (md[i])
      for (int v = 0; v < 3; v++) begin
        mode = md[i];
        variant = slm_variant_e'(v);
        repeat (8) send();
        in_valid = 1'b0;
        while (exq.size() != 0) @(negedge sys_clk);
      end
    end_of_test();
  end
endmodule

/* File: tb/slm_sink.sv */
/* far-side sink model: accepts lane frames with random stalls.
   assumes the bench has seeded $urandom */
module slm_sink (
  input wire logic sys_clk,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // stall about one cycle in three so held frames get exercised
  always @(negedge sys_clk) out_ready <= ($urandom % 3) != 0;
endmodule
